// ### src/pld_macro_pkg.sv
package pld_macro_pkg;

	// Array shape
	localparam int NUM_GROUPS  = 4;
	localparam int GROUP_SIZE  = 4;
	localparam int NUM_CELLS   = NUM_GROUPS * GROUP_SIZE;
	localparam int DUAL_PER_GROUP = 2;
	localparam int NUM_DUAL    = NUM_GROUPS * DUAL_PER_GROUP;
	localparam int NUM_SINGLE  = NUM_CELLS - NUM_DUAL;
	localparam int NUM_CLK_PINS = 2;

	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_GLOBAL    = 8'h04;
	localparam logic [7:0] OFS_PRELOAD   = 8'h08;
	localparam logic [7:0] OFS_OE_CFG    = 8'h0C;
	localparam logic [7:0] OFS_CLK_SEL   = 8'h10;
	localparam logic [7:0] OFS_CLK_INV   = 8'h14;
	localparam logic [7:0] OFS_LATCH     = 8'h18;
	localparam logic [7:0] OFS_SINGLE_FB = 8'h1C;
	localparam logic [7:0] OFS_STATE     = 8'h20;
	localparam logic [7:0] OFS_PINS      = 8'h24;

	// Field positions
	localparam int CTRL_OBSERVE_BIT = 0;
	localparam int GLOBAL_OP_LSB    = 0;
	localparam int OE_FIELD_W       = 2;

	// Reset values
	localparam logic [7:0]  OE_CFG_RST   = 8'h00;
	localparam logic [15:0] CLK_SEL_RST  = 16'h0000;
	localparam logic [15:0] CLK_INV_RST  = 16'h0000;
	localparam logic [15:0] LATCH_RST    = 16'h0000;
	localparam logic [15:0] PRELOAD_RST  = 16'h0000;
	localparam logic [7:0]  SINGLE_FB_RST = 8'h00;
	localparam logic [15:0] STATE_RST    = 16'h0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Output-enable source of one group
	typedef enum logic [1:0] {OE_PIN, OE_XOR, OE_ON, OE_OFF} oe_src_t;

	// Global preset, reset and preload operations
	typedef enum logic [1:0] {GLB_NONE, GLB_PRESET, GLB_RESET, GLB_PRELOAD} glb_op_t;

	// Bus slave state
	typedef struct packed {
		logic        awHave;
		logic        wHave;
		logic [7:0]  awAddr;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} slave_state_t;

	// Write request handed to the register file
	typedef struct packed {
		logic        en;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_req_t;

	// Macrocell array state
	typedef struct packed {
		logic        observe;
		logic [7:0]  oeCfg;
		logic [15:0] clkSel;
		logic [15:0] clkInv;
		logic [15:0] latchMode;
		logic [15:0] preload;
		logic [7:0]  singleFbPin;
		logic [15:0] q;
		logic [1:0]  pinPrev;
	} core_state_t;

	// Byte-lane merge of a write into a 32-bit image
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (data & m);
	endfunction

endpackage

// ### src/axil_cfg_slave.sv
`timescale 1ns/1ns
`default_nettype none
module axil_cfg_slave (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	// AXI4-Lite write
	input  wire logic [7:0]           awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	// AXI4-Lite read
	input  wire logic [7:0]           araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// Register file side
	output pld_macro_pkg::wr_req_t    wrReq,
	input  wire logic                 wrOk,
	input  wire logic [31:0]          rdData,
	input  wire logic                 rdOk
);
	import pld_macro_pkg::*;

	slave_state_t stReg;
	slave_state_t stNext;

	// Ready only while the holding slot is empty and no response is pending
	assign awready = !stReg.awHave && !stReg.bvalid;
	assign wready  = !stReg.wHave && !stReg.bvalid;
	assign arready = !stReg.rvalid;
	assign bvalid  = stReg.bvalid;
	assign bresp   = stReg.bresp;
	assign rvalid  = stReg.rvalid;
	assign rdata   = stReg.rdata;
	assign rresp   = stReg.rresp;

	// Write fires once address and data are both held
	always_comb begin
		wrReq.en   = stReg.awHave && stReg.wHave;
		wrReq.addr = stReg.awAddr;
		wrReq.data = stReg.wData;
		wrReq.strb = stReg.wStrb;
	end

	// Channel bookkeeping
	always_comb begin
		stNext = stReg;
		if (awvalid && awready) begin
			stNext.awHave = 1'b1;
			stNext.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			stNext.wHave = 1'b1;
			stNext.wData = wdata;
			stNext.wStrb = wstrb;
		end
		if (wrReq.en) begin
			stNext.awHave = 1'b0;
			stNext.wHave  = 1'b0;
			stNext.bvalid = 1'b1;
			stNext.bresp  = wrOk ? RESP_OKAY : RESP_SLVERR;
		end
		if (stReg.bvalid && bready) begin
			stNext.bvalid = 1'b0;
		end
		// Read data is latched at the address handshake so it cannot shift
		if (arvalid && arready) begin
			stNext.rvalid = 1'b1;
			stNext.rdata  = rdData;
			stNext.rresp  = rdOk ? RESP_OKAY : RESP_SLVERR;
		end else if (stReg.rvalid && rready) begin
			stNext.rvalid = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			stReg <= '0;
		end else begin
			stReg <= stNext;
		end
	end
endmodule
`default_nettype wire

// ### src/pld_macrocell_array.sv
// Operation
// - Each four-output group shares one enable: pin, XOR of terms, on, off.
// - Sixteen outputs in four groups, each two dual and two single cells.
// - Each flip-flop picks either of two clock or latch-enable pins.
// - Inverted select gives falling edge or low latch; else rising or high.
// - Single cells feed back one signal; dual cells feed back register and pin.
// - Dual cells keep a buried register feedback apart from the pin path.
// - One global control presets, resets or preloads every register together.
// - One observe control shows buried register states on the outputs of every group not set off.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pld_macrocell_array (
	// Clock and reset
	input  wire logic                                  core_clk,
	input  wire logic                                  reset,
	// AXI4-Lite write
	input  wire logic [7:0]                            awaddr,
	input  wire logic                                  awvalid,
	output logic                                       awready,
	input  wire logic [31:0]                           wdata,
	input  wire logic [3:0]                            wstrb,
	input  wire logic                                  wvalid,
	output logic                                       wready,
	output logic [1:0]                                 bresp,
	output logic                                       bvalid,
	input  wire logic                                  bready,
	// AXI4-Lite read
	input  wire logic [7:0]                            araddr,
	input  wire logic                                  arvalid,
	output logic                                       arready,
	output logic [31:0]                                rdata,
	output logic [1:0]                                 rresp,
	output logic                                       rvalid,
	input  wire logic                                  rready,
	// Clock or latch-enable pins and external enable pin
	input  wire logic [pld_macro_pkg::NUM_CLK_PINS-1:0] latchEnPin,
	input  wire logic                                  oePin,
	// Array side: next-state terms and XOR enable product terms
	input  wire logic [pld_macro_pkg::NUM_CELLS-1:0]   cellD,
	input  wire logic [pld_macro_pkg::NUM_GROUPS-1:0]  oeTermA,
	input  wire logic [pld_macro_pkg::NUM_GROUPS-1:0]  oeTermB,
	// Output pins, split into level in, drive and enable
	input  wire logic [pld_macro_pkg::NUM_CELLS-1:0]   ioIn,
	output logic [pld_macro_pkg::NUM_CELLS-1:0]        ioOut,
	output logic [pld_macro_pkg::NUM_CELLS-1:0]        ioOe,
	// Feedback into the array
	output logic [pld_macro_pkg::NUM_SINGLE-1:0]       singleFb,
	output logic [pld_macro_pkg::NUM_DUAL-1:0]         dualIoFb,
	output logic [pld_macro_pkg::NUM_DUAL-1:0]         dualCellBuriedFb
);
	import pld_macro_pkg::*;

	core_state_t stReg;
	core_state_t stNext;
	wr_req_t     wrReq;
	logic        wrOk;
	logic [31:0] rdData;
	logic        rdOk;
	glb_op_t     glbOp;

	axil_cfg_slave u_slave (
		.core_clk (core_clk),
		.reset    (reset),
		.awaddr   (awaddr),
		.awvalid  (awvalid),
		.awready  (awready),
		.wdata    (wdata),
		.wstrb    (wstrb),
		.wvalid   (wvalid),
		.wready   (wready),
		.bresp    (bresp),
		.bvalid   (bvalid),
		.bready   (bready),
		.araddr   (araddr),
		.arvalid  (arvalid),
		.arready  (arready),
		.rdata    (rdata),
		.rresp    (rresp),
		.rvalid   (rvalid),
		.rready   (rready),
		.wrReq    (wrReq),
		.wrOk     (wrOk),
		.rdData   (rdData),
		.rdOk     (rdOk)
	);

	// Write decode; the global register is a command, not storage
	always_comb begin
		wrOk = 1'b1;
		unique case (wrReq.addr)
			OFS_CONTROL, OFS_GLOBAL, OFS_PRELOAD, OFS_OE_CFG, OFS_CLK_SEL,
			OFS_CLK_INV, OFS_LATCH, OFS_SINGLE_FB, OFS_STATE, OFS_PINS: wrOk = 1'b1;
			default: wrOk = 1'b0;
		endcase
	end

	// Read decode; state and pin words show live block state
	always_comb begin
		rdData = 32'h0000_0000;
		rdOk   = 1'b1;
		unique case (araddr)
			OFS_CONTROL:   rdData[CTRL_OBSERVE_BIT] = stReg.observe;
			OFS_GLOBAL:    rdData = 32'h0000_0000;
			OFS_PRELOAD:   rdData[15:0] = stReg.preload;
			OFS_OE_CFG:    rdData[7:0] = stReg.oeCfg;
			OFS_CLK_SEL:   rdData[15:0] = stReg.clkSel;
			OFS_CLK_INV:   rdData[15:0] = stReg.clkInv;
			OFS_LATCH:     rdData[15:0] = stReg.latchMode;
			OFS_SINGLE_FB: rdData[7:0] = stReg.singleFbPin;
			OFS_STATE:     rdData[15:0] = stReg.q;
			OFS_PINS:      rdData[15:0] = ioIn;
			default:       rdOk = 1'b0;
		endcase
	end

	// A global command acts in the cycle its write lands
	always_comb begin
		glbOp = GLB_NONE;
		if (wrReq.en && wrReq.addr == OFS_GLOBAL && wrReq.strb[0]) begin
			glbOp = glb_op_t'(wrReq.data[GLOBAL_OP_LSB +: 2]);
		end
	end

	// Register writes and storage element update
	always_comb begin
		logic [31:0] img;
		logic        pinNow;
		logic        pinOld;
		logic        actNow;
		logic        actOld;
		img    = 32'h0000_0000;
		pinNow = 1'b0;
		pinOld = 1'b0;
		actNow = 1'b0;
		actOld = 1'b0;
		stNext = stReg;
		stNext.pinPrev = latchEnPin;
		if (wrReq.en) begin
			unique case (wrReq.addr)
				OFS_CONTROL: begin
					img = merge({31'h0000_0000, stReg.observe}, wrReq.data, wrReq.strb);
					stNext.observe = img[CTRL_OBSERVE_BIT];
				end
				OFS_PRELOAD: begin
					img = merge({16'h0000, stReg.preload}, wrReq.data, wrReq.strb);
					stNext.preload = img[15:0];
				end
				OFS_OE_CFG: begin
					img = merge({24'h00_0000, stReg.oeCfg}, wrReq.data, wrReq.strb);
					stNext.oeCfg = img[7:0];
				end
				OFS_CLK_SEL: begin
					img = merge({16'h0000, stReg.clkSel}, wrReq.data, wrReq.strb);
					stNext.clkSel = img[15:0];
				end
				OFS_CLK_INV: begin
					img = merge({16'h0000, stReg.clkInv}, wrReq.data, wrReq.strb);
					stNext.clkInv = img[15:0];
				end
				OFS_LATCH: begin
					img = merge({16'h0000, stReg.latchMode}, wrReq.data, wrReq.strb);
					stNext.latchMode = img[15:0];
				end
				OFS_SINGLE_FB: begin
					img = merge({24'h00_0000, stReg.singleFbPin}, wrReq.data, wrReq.strb);
					stNext.singleFbPin = img[7:0];
				end
				default: ;
			endcase
		end
		// Pins are sampled, so an edge is seen one cycle after it occurs
		for (int i = 0; i < NUM_CELLS; i++) begin
			pinNow = latchEnPin[stReg.clkSel[i]];
			pinOld = stReg.pinPrev[stReg.clkSel[i]];
			actNow = pinNow ^ stReg.clkInv[i];
			actOld = pinOld ^ stReg.clkInv[i];
			if (stReg.latchMode[i]) begin
				if (actNow) begin
					stNext.q[i] = cellD[i];
				end
			end else if (actNow && !actOld) begin
				stNext.q[i] = cellD[i];
			end
		end
		// Global control wins over any capture in the same cycle
		unique case (glbOp)
			GLB_PRESET:  stNext.q = '1;
			GLB_RESET:   stNext.q = '0;
			GLB_PRELOAD: stNext.q = stReg.preload;
			GLB_NONE:    ;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			stReg.observe     <= 1'b0;
			stReg.oeCfg       <= OE_CFG_RST;
			stReg.clkSel      <= CLK_SEL_RST;
			stReg.clkInv      <= CLK_INV_RST;
			stReg.latchMode   <= LATCH_RST;
			stReg.preload     <= PRELOAD_RST;
			stReg.singleFbPin <= SINGLE_FB_RST;
			stReg.q           <= STATE_RST;
			stReg.pinPrev     <= '0;
		end else begin
			stReg <= stNext;
		end
	end

	// Register state drives the pins; observe also enables every cell of each group not set off
	assign ioOut = stReg.q;

	// Group enables and feedback routing
	always_comb begin
		logic    grpEn;
		oe_src_t src;
		int      k;
		grpEn = 1'b0;
		src   = OE_PIN;
		k     = 0;
		ioOe  = '0;
		singleFb = '0;
		dualIoFb = '0;
		dualCellBuriedFb = '0;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			src = oe_src_t'(stReg.oeCfg[OE_FIELD_W*g +: OE_FIELD_W]);
			unique case (src)
				OE_PIN: grpEn = oePin;
				OE_XOR: grpEn = oeTermA[g] ^ oeTermB[g];
				OE_ON:  grpEn = 1'b1;
				OE_OFF: grpEn = 1'b0;
			endcase
			// Observe forces drive for test, but an off group stays released
			if (stReg.observe && src != OE_OFF) begin
				grpEn = 1'b1;
			end
			for (int j = 0; j < GROUP_SIZE; j++) begin
				ioOe[g*GROUP_SIZE+j] = grpEn;
				if (j < DUAL_PER_GROUP) begin
					k = g*DUAL_PER_GROUP + j;
					dualCellBuriedFb[k] = stReg.q[g*GROUP_SIZE+j];
					dualIoFb[k] = ioIn[g*GROUP_SIZE+j];
				end else begin
					k = g*DUAL_PER_GROUP + j - DUAL_PER_GROUP;
					singleFb[k] = stReg.singleFbPin[k] ? ioIn[g*GROUP_SIZE+j]
						: stReg.q[g*GROUP_SIZE+j];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/pld_macro_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pld_macro_checker (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        reset,
	// Register bus
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [3:0]  wstrb,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	// Pins and feedback
	input wire logic [15:0] ioIn,
	input wire logic [15:0] ioOut,
	input wire logic [15:0] ioOe,
	input wire logic [7:0]  singleFb,
	input wire logic [7:0]  dualIoFb,
	input wire logic [7:0]  dualCellBuriedFb
);
	import pld_macro_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Both write halves in one cycle; a preset-all command
	sequence wrBoth;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence presetCmd;
		wrBoth ##0 (awaddr == OFS_GLOBAL && wdata[GLOBAL_OP_LSB +: 2] == GLB_PRESET && wstrb[0]);
	endsequence
	chk_write_answer: assert property (wrBoth |-> ##2 bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	chk_reset_clean: assert property ($fell(reset) |-> ioOut == 16'h0000 && !bvalid && !rvalid)
		else $error("state not cleared");
	chk_preset_all: assert property (presetCmd |-> ##2 ioOut == 16'hFFFF)
		else $error("preset missed cells");
	// Whole group switches together
	for (genvar g = 0; g < 4; g++) begin : grp
		chk_group_share: assert property (&ioOe[4*g+:4] || !(|ioOe[4*g+:4]))
			else $error("group enables differ");
	end
	// Dual cells sit at positions 0 and 1 of a group, single cells at 2 and 3
	for (genvar k = 0; k < 8; k++) begin : fb
		localparam int D = (k / 2) * 4 + k % 2;
		chk_dual_pin: assert property (dualIoFb[k] == ioIn[D])
			else $error("pin feedback wrong");
		chk_buried_fb: assert property (dualCellBuriedFb[k] == ioOut[D])
			else $error("buried feedback wrong");
		chk_single_fb: assert property (singleFb[k] == ioOut[D+2] || singleFb[k] == ioIn[D+2])
			else $error("single feedback wrong");
	end
endmodule
bind pld_macrocell_array pld_macro_checker chk (.core_clk, .reset, .awaddr, .awvalid, .awready,
	.wdata, .wvalid, .wready, .wstrb, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
	.rvalid, .rready, .ioIn, .ioOut, .ioOe, .singleFb, .dualIoFb, .dualCellBuriedFb);
`default_nettype wire

// ### dv/board_model.sv
`timescale 1ns/1ns
`default_nettype none
module board_model (
	// Clock and bench commands
	input wire logic        core_clk,
	input wire logic        pulseGo,
	input wire logic        pulseSel,
	// Device pins
	input wire logic [15:0] ioOut,
	input wire logic [15:0] ioOe,
	output logic [1:0]      latchEnPin,
	output logic [15:0]     ioIn
);
	logic [2:0]  pulseCnt = 3'h0;
	logic [15:0] floatPat = 16'h5A3C;
	// Clock pins rest low; a pulse stays high six cycles
	initial latchEnPin = 2'h0;
	always @(posedge core_clk) begin
		floatPat <= ~floatPat;
		if (pulseGo) begin
			pulseCnt <= 3'h6;
			latchEnPin[pulseSel] <= 1'b1;
		end else if (pulseCnt != 3'h0) begin
			pulseCnt <= pulseCnt - 3'h1;
			if (pulseCnt == 3'h1)
				latchEnPin <= 2'h0;
		end
	end
	// Undriven pins flip every cycle, so a stale value never passes
	assign ioIn = (ioOe & ioOut) | (~ioOe & floatPat);
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pld_macro_pkg::*;
	logic        core_clk, reset, oePin, pulseGo, pulseSel;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, singleFb, dualIoFb, dualCellBuriedFb;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  wstrb, oeTermA, oeTermB;
	logic [1:0]  bresp, rresp, latchEnPin, rr;
	logic [15:0] cellD, ioIn, ioOut, ioOe;
	int          errors, total_checks;

	pld_macrocell_array dut (.core_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .latchEnPin, .oePin, .cellD, .oeTermA, .oeTermB, .ioIn,
		.ioOut, .ioOe, .singleFb, .dualIoFb, .dualCellBuriedFb);
	board_model partner (.core_clk, .pulseGo, .pulseSel, .ioOut, .ioOe, .latchEnPin, .ioIn);

	// Core clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic hang(input int n);
		if (n >= 50) begin
			errors++;
			$display("mismatch at %0t: bus answer never came", $time);
			test_done();
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Bus write; slow holds bready back until the answer shows
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic slow = 1'b0);
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow;
		n = 0;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b1;
			n++;
		end while (!(bvalid && bready) && n < 50);
		hang(n);
		rr = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic slow = 1'b0);
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !slow;
		n = 0;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b1;
			n++;
		end while (!(rvalid && rready) && n < 50);
		hang(n);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	// One pulse on a clock pin, seen by the board next edge
	task automatic pulse(input logic sel);
		pulseSel <= sel;
		pulseGo <= 1'b1;
		tick(1);
		pulseGo <= 1'b0;
	endtask

	function automatic logic [7:0] pick(input logic [15:0] v, input int off);
		for (int k = 0; k < 8; k++)
			pick[k] = v[(k / 2) * 4 + k % 2 + off];
	endfunction

	// Reset values, read-only state and an unmapped hole
	task automatic t_regs();
		for (int a = 0; a <= 32; a += 4) begin
			rd(8'(a), a == 0);
			chk(rv, 32'h0000_0000);
			chk(rr, RESP_OKAY);
		end
		wr(OFS_STATE, 32'h0000_BEEF, 1'b1);
		chk(rr, RESP_OKAY);
		rd(OFS_STATE);
		chk(rv, 32'h0000_0000);
		wr(8'h40, 32'h0000_0001);
		chk(rr, RESP_SLVERR);
		rd(8'h40);
		chk(rr, RESP_SLVERR);
		$display("register test done");
	endtask

	// Every enable mode on every group, both pin levels, observe off and on
	task automatic t_oe();
		logic [7:0]  cfg;
		logic [15:0] exp;
		logic [1:0]  m;
		logic        en;
		oeTermA <= 4'b0011;
		oeTermB <= 4'b0101;
		for (int r = 0; r < 4; r++) begin
			for (int g = 0; g < 4; g++)
				cfg[2*g+:2] = 2'(g + r);
			wr(OFS_OE_CFG, 32'(cfg));
			for (int ob = 0; ob < 2; ob++) begin
				wr(OFS_CONTROL, 32'(ob));
				for (int p = 0; p < 2; p++) begin
					oePin <= p[0];
					tick(2);
					for (int g = 0; g < 4; g++) begin
						m = cfg[2*g+:2];
						en = m == OE_PIN ? p[0] : m == OE_XOR ? oeTermA[g] ^ oeTermB[g] : m == OE_ON;
						exp[4*g+:4] = {4{(en || ob == 1) && m != OE_OFF}};
					end
					chk(ioOe, exp);
				end
			end
		end
		wr(OFS_CONTROL, 32'h0000_0000);
		$display("enable test done");
	endtask

	// Per-cell pin and polarity; rising cells take the first value, falling ones the second
	task automatic t_clock();
		wr(OFS_CLK_SEL, 32'h0000_FF00);
		wr(OFS_CLK_INV, 32'h0000_F0F0);
		cellD <= 16'h1234;
		pulse(1'b0);
		tick(3);
		cellD <= 16'h5678;
		tick(7);
		chk(ioOut, 16'h0074);
		cellD <= 16'h9ABC;
		pulse(1'b1);
		tick(3);
		cellD <= 16'hDEF0;
		tick(7);
		chk(ioOut, 16'hDA74);
		// Latches: high byte open while the pin is low, low byte while high
		wr(OFS_CLK_SEL, 32'h0000_0000);
		wr(OFS_CLK_INV, 32'h0000_FF00);
		wr(OFS_LATCH, 32'h0000_FFFF);
		cellD <= 16'h1E1E;
		pulse(1'b0);
		tick(3);
		cellD <= 16'h2D2D;
		tick(2);
		chk(ioOut, 16'h1E2D);
		tick(6);
		cellD <= 16'h4B4B;
		tick(3);
		chk(ioOut, 16'h4B2D);
		wr(OFS_LATCH, 32'h0000_0000);
		wr(OFS_CLK_INV, 32'h0000_0000);
		$display("clock test done");
	endtask

	// Global commands with every group off; then both feedback choices
	task automatic t_global();
		logic [15:0] exp;
		logic [1:0]  cmd [3] = '{2'h3, 2'h2, 2'h1};
		wr(OFS_OE_CFG, 32'h0000_00FF);
		wr(OFS_PRELOAD, 32'h0000_3C5A);
		for (int i = 0; i < 3; i++) begin
			exp = cmd[i] == GLB_PRELOAD ? 16'h3C5A : {16{cmd[i] == GLB_PRESET}};
			wr(OFS_GLOBAL, 32'(cmd[i]));
			rd(OFS_STATE);
			chk(rv, 32'(exp));
			chk(ioOut, exp);
			chk(dualCellBuriedFb, pick(exp, 0));
			chk(ioOe, 16'h0000);
		end
		// An empty command must leave every cell alone
		wr(OFS_GLOBAL, 32'h0000_0000);
		chk(ioOut, 16'hFFFF);
		wr(OFS_SINGLE_FB, 32'h0000_00FF);
		chk(singleFb, pick(ioIn, 2));
		chk(dualIoFb, pick(ioIn, 0));
		wr(OFS_SINGLE_FB, 32'h0000_0000);
		chk(singleFb, pick(ioOut, 2));
		// All groups on, so the pin word must show the preset register state
		wr(OFS_OE_CFG, 32'h0000_00AA);
		rd(OFS_PINS);
		chk(rv, 32'h0000_FFFF);
		chk(dualIoFb, 8'hFF);
		$display("global test done");
	endtask

	// Reset, then each scenario in turn
	initial begin
		errors = 0;
		total_checks = 0;
		reset = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, oePin, pulseGo, pulseSel} = '0;
		{awaddr, araddr, wdata, wstrb, cellD, oeTermA, oeTermB} = '0;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		t_regs();
		t_oe();
		t_clock();
		t_global();
		test_done();
	end
endmodule
`default_nettype wire
